// ### rtl/op_signed_multiply_div_unit_pkg.sv
// constants and types shared by the multiply/divide unit files
// assumes a single core clock and a synchronous active-high reset
package op_signed_multiply_div_unit_pkg;

   localparam int unsigned DATA_W  = 32;
   localparam int unsigned SLICE_W = 16;
   localparam int unsigned PROD_W  = 50;
   localparam int unsigned REG_CNT = 32;
   localparam int unsigned ADDR_W  = 5;

   // sign-extension test positions (top bit of each short width)
   localparam int unsigned TOP_8  = 7;
   localparam int unsigned TOP_16 = 15;
   localparam int unsigned TOP_24 = 23;

   // divide: skipped iterations per dividend width
   localparam logic [5:0] DIV_SKIP_8  = 6'h17;
   localparam logic [5:0] DIV_SKIP_16 = 6'h0f;
   localparam logic [5:0] DIV_SKIP_24 = 6'h07;
   localparam logic [5:0] DIV_SKIP_32 = 6'h00;
   localparam logic [5:0] DIV_FULL    = 6'h20;

   // divide latency and repeat rate, in core clocks
   localparam logic [5:0] DIV_LAT_8  = 6'h0c;
   localparam logic [5:0] DIV_LAT_16 = 6'h13;
   localparam logic [5:0] DIV_LAT_24 = 6'h1a;
   localparam logic [5:0] DIV_LAT_32 = 6'h21;
   localparam logic [5:0] DIV_REP_8  = 6'h0b;
   localparam logic [5:0] DIV_REP_16 = 6'h12;
   localparam logic [5:0] DIV_REP_24 = 6'h19;
   localparam logic [5:0] DIV_REP_32 = 6'h20;

   typedef enum logic [3:0] {
      op_signed_multiply,
      op_unsigned_multiply,
      op_signed_multiply_accumulate,
      op_unsigned_multiply_accumulate,
      op_signed_multiply_subtract,
      op_unsigned_multiply_subtract,
      op_multiply_to_register,
      op_signed_divide,
      op_unsigned_divide
   } op_t;

   typedef enum logic {
      div_idle,
      div_run
   } div_state_t;

endpackage

// ### rtl/booth_slice_multiplier.sv
// radix-4 booth multiplier: 32-bit operand times one 16-bit slice
// assumes callers pick the slice and say whether each side is signed
`timescale 1ns/1ps
module booth_slice_multiplier
   import op_signed_multiply_div_unit_pkg::*;
(
   input  wire logic [31:0]        a,
   input  wire logic               a_signed,
   input  wire logic [15:0]        b,
   input  wire logic               b_signed,
   output logic signed [PROD_W-1:0] product
);

   logic [18:0]              bx;
   logic signed [PROD_W-1:0] a_ext;
   logic signed [PROD_W-1:0] acc;
   logic signed [PROD_W-1:0] pp;
   logic [2:0]               dig;

   always_comb begin
      // two extension bits so the top digit sees the slice sign
      bx    = {{2{b_signed & b[15]}}, b, 1'b0};
      a_ext = {{(PROD_W-32){a_signed & a[31]}}, a};
      acc   = '0;
      pp    = '0;
      dig   = '0;
      for (int i = 0; i < 9; i++) begin
         dig = bx[2*i +: 3];
         case (dig)
            3'h1, 3'h2: pp = a_ext;
            3'h3:       pp = a_ext <<< 1;
            3'h4:       pp = -(a_ext <<< 1);
            3'h5, 3'h6: pp = -a_ext;
            default:    pp = '0;
         endcase
         acc = acc + (pp <<< (2*i));
      end
      product = acc;
   end

endmodule

// ### rtl/op_signed_multiply_div_unit.sv
// multiply/divide unit with its operand register file
// assumes the integer pipeline holds an issue while ISSUE_STALL is high
`timescale 1ns/1ps
module op_signed_multiply_div_unit
   import op_signed_multiply_div_unit_pkg::*;
(
   input  wire logic              CORE_CLK,
   input  wire logic              RST,
   input  wire logic              RF_WR_EN,
   input  wire logic [ADDR_W-1:0] RF_WR_ADDR,
   input  wire logic [31:0]       RF_WR_DATA,
   input  wire logic              ISSUE_VALID,
   input  wire op_t               ISSUE_OP,
   input  wire logic [ADDR_W-1:0] ISSUE_SRC_A,
   input  wire logic [ADDR_W-1:0] ISSUE_SRC_B,
   input  wire logic [ADDR_W-1:0] ISSUE_DEST,
   output logic                   ISSUE_STALL,
   output logic [31:0]            RESULT_HIGH,
   output logic [31:0]            RESULT_LOW,
   output logic [31:0]            MUL_RESULT,
   output logic [ADDR_W-1:0]      MUL_RESULT_DEST,
   output logic                   MUL_RESULT_VALID,
   output logic                   DIV_BUSY
);

   function automatic logic is_mul(input op_t op);
      return !(op == op_signed_divide || op == op_unsigned_divide);
   endfunction

   function automatic logic is_signed(input op_t op);
      return op == op_signed_multiply
          || op == op_signed_multiply_accumulate
          || op == op_signed_multiply_subtract
          || op == op_signed_divide;
   endfunction

   // true when v is just the extension of its low bits up to 'top'
   function automatic logic fits(input logic [31:0] v, input logic sgn,
                                 input int unsigned top);
      logic ext;
      logic ok;
      ext = sgn & v[top];
      ok  = 1'b1;
      for (int i = 0; i < 32; i++) begin
         if (i > top && v[i] != ext) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   // ---------------- register file ----------------
   logic [31:0] general_registers [REG_CNT];
   logic [31:0] first_source_operand;
   logic [31:0] second_source_operand;

   always_comb begin
      first_source_operand  = general_registers[ISSUE_SRC_A];
      second_source_operand = general_registers[ISSUE_SRC_B];
      if (RF_WR_EN && RF_WR_ADDR == ISSUE_SRC_A) begin
         first_source_operand = RF_WR_DATA;
      end
      if (RF_WR_EN && RF_WR_ADDR == ISSUE_SRC_B) begin
         second_source_operand = RF_WR_DATA;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RF_WR_EN) begin
         general_registers[RF_WR_ADDR] <= RF_WR_DATA;
      end
   end

   // ---------------- issue and interlocks ----------------
   logic        mst_valid_q, mst_valid_d;
   op_t         mst_op_q, mst_op_d;
   logic [31:0] mst_a_q, mst_a_d;
   logic [31:0] mst_b_q, mst_b_d;
   logic        mst_long_q, mst_long_d;
   logic        mst_pass_q, mst_pass_d;
   logic [ADDR_W-1:0] mst_dest_q, mst_dest_d;
   logic signed [63:0] part_q, part_d;
   div_state_t  div_state_q, div_state_d;
   logic [5:0]  cyc_q, cyc_d;
   logic [5:0]  iter_q, iter_d;
   logic [5:0]  lat_q, lat_d;
   logic [5:0]  rep_q, rep_d;
   logic        long_pending;
   logic        div_done;
   logic        div_gate;
   logic        issue_take;
   logic        b_short;

   assign long_pending = mst_valid_q && mst_long_q && !mst_pass_q;
   assign div_done     = div_state_q == div_run && cyc_q == lat_q - 6'h01;
   // other work may enter once the repeat interval has run out
   assign div_gate     = div_state_q == div_run && cyc_q + 6'h01 < rep_q;
   assign b_short = fits(second_source_operand, is_signed(ISSUE_OP),
                         TOP_16);

   always_comb begin
      ISSUE_STALL = 1'b0;
      if (ISSUE_VALID) begin
         if (div_gate) begin
            ISSUE_STALL = 1'b1;
         end else if (!is_mul(ISSUE_OP) && div_state_q == div_run
                      && !div_done) begin
            ISSUE_STALL = 1'b1;
         end else if (is_mul(ISSUE_OP) && long_pending) begin
            ISSUE_STALL = 1'b1;
         end
      end
   end
   assign issue_take = ISSUE_VALID && !ISSUE_STALL;

   // ---------------- multiply pipeline ----------------
   logic               sl_signed;
   logic [15:0]        slice;
   logic signed [PROD_W-1:0] slice_prod;
   logic signed [63:0] prod;
   logic signed [63:0] base;
   logic signed [63:0] final_acc;
   logic               mst_final;
   logic               hilo_write;

   // second pass takes the upper slice; in a long multiply only it carries the sign
   assign slice     = mst_pass_q ? mst_b_q[31:16] : mst_b_q[15:0];
   assign sl_signed = is_signed(mst_op_q) && !long_pending;

   booth_slice_multiplier u_booth (
      .a        (mst_a_q),
      .a_signed (is_signed(mst_op_q)),
      .b        (slice),
      .b_signed (sl_signed),
      .product  (slice_prod)
   );

   assign mst_final  = mst_valid_q && (!mst_long_q || mst_pass_q);
   assign hilo_write = mst_final && mst_op_q != op_multiply_to_register;

   logic [31:0] div_q_res;
   logic [31:0] div_r_res;

   always_comb begin
      prod = 64'(slice_prod);
      if (mst_pass_q) begin
         prod = part_q + (64'(slice_prod) <<< 16);
      end
      // a divide retiring this edge is the older value to accumulate on
      base = div_done ? {div_r_res, div_q_res} : {RESULT_HIGH, RESULT_LOW};
      unique case (mst_op_q)
         op_signed_multiply_accumulate,
         op_unsigned_multiply_accumulate: final_acc = base + prod;
         op_signed_multiply_subtract,
         op_unsigned_multiply_subtract:   final_acc = base - prod;
         default:                         final_acc = prod;
      endcase
   end

   always_comb begin
      mst_valid_d = mst_valid_q;
      mst_op_d    = mst_op_q;
      mst_a_d     = mst_a_q;
      mst_b_d     = mst_b_q;
      mst_long_d  = mst_long_q;
      mst_pass_d  = mst_pass_q;
      mst_dest_d  = mst_dest_q;
      part_d      = part_q;
      if (issue_take && is_mul(ISSUE_OP)) begin
         mst_valid_d = 1'b1;
         mst_op_d    = ISSUE_OP;
         mst_a_d     = first_source_operand;
         mst_b_d     = second_source_operand;
         mst_long_d  = !b_short;
         mst_pass_d  = 1'b0;
         mst_dest_d  = ISSUE_DEST;
      end else if (mst_final) begin
         mst_valid_d = 1'b0;
      end else if (long_pending) begin
         mst_pass_d = 1'b1;
         part_d     = prod;
      end
   end

   // stages advance every clock; no integer-side stall reaches them
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         mst_valid_q <= 1'b0;
         mst_op_q    <= op_signed_multiply;
         mst_a_q     <= '0;
         mst_b_q     <= '0;
         mst_long_q  <= 1'b0;
         mst_pass_q  <= 1'b0;
         mst_dest_q  <= '0;
         part_q      <= '0;
      end else begin
         mst_valid_q <= mst_valid_d;
         mst_op_q    <= mst_op_d;
         mst_a_q     <= mst_a_d;
         mst_b_q     <= mst_b_d;
         mst_long_q  <= mst_long_d;
         mst_pass_q  <= mst_pass_d;
         mst_dest_q  <= mst_dest_d;
         part_q      <= part_d;
      end
   end

   // ---------------- result registers ----------------
   logic [31:0] hi_d, lo_d;
   logic        r1_valid_q, r1_valid_d;
   logic [31:0] r1_data_q, r1_data_d;
   logic [ADDR_W-1:0] r1_dest_q, r1_dest_d;

   always_comb begin
      hi_d       = RESULT_HIGH;
      lo_d       = RESULT_LOW;
      if (hilo_write) begin
         {hi_d, lo_d} = final_acc;
      end else if (div_done) begin
         hi_d = div_r_res;
         lo_d = div_q_res;
      end
      // three-operand result waits one stage more than high/low
      r1_valid_d = mst_final && !hilo_write;
      r1_data_d  = prod[31:0];
      r1_dest_d  = mst_dest_q;
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         RESULT_HIGH      <= '0;
         RESULT_LOW       <= '0;
         r1_valid_q       <= 1'b0;
         r1_data_q        <= '0;
         r1_dest_q        <= '0;
         MUL_RESULT_VALID <= 1'b0;
         MUL_RESULT       <= '0;
         MUL_RESULT_DEST  <= '0;
      end else begin
         RESULT_HIGH      <= hi_d;
         RESULT_LOW       <= lo_d;
         r1_valid_q       <= r1_valid_d;
         r1_data_q        <= r1_data_d;
         r1_dest_q        <= r1_dest_d;
         MUL_RESULT_VALID <= r1_valid_q;
         MUL_RESULT       <= r1_data_q;
         MUL_RESULT_DEST  <= r1_dest_q;
      end
   end

   // ---------------- divider ----------------
   logic [31:0] dvd_q, dvd_d;
   logic [31:0] dsr_q, dsr_d;
   logic [31:0] rem_q, rem_d;
   logic        qneg_q, qneg_d;
   logic        rneg_q, rneg_d;
   logic [31:0] mag_a, mag_b;
   logic [5:0]  skip;
   logic [32:0] shifted;
   logic [33:0] trial;
   logic        sa, sb;

   assign sa = is_signed(ISSUE_OP) & first_source_operand[31];
   assign sb = is_signed(ISSUE_OP) & second_source_operand[31];
   assign mag_a = sa ? -first_source_operand : first_source_operand;
   assign mag_b = sb ? -second_source_operand : second_source_operand;
   assign div_q_res = qneg_q ? -dvd_q : dvd_q;
   assign div_r_res = rneg_q ? -rem_q : rem_q;
   assign DIV_BUSY  = div_state_q == div_run;
   assign shifted   = {rem_q, dvd_q[31]};
   assign trial     = {1'b0, shifted} - {2'h0, dsr_q};

   always_comb begin
      div_state_d = div_state_q;
      cyc_d  = cyc_q;
      iter_d = iter_q;
      lat_d  = lat_q;
      rep_d  = rep_q;
      dvd_d  = dvd_q;
      dsr_d  = dsr_q;
      rem_d  = rem_q;
      qneg_d = qneg_q;
      rneg_d = rneg_q;
      skip   = DIV_SKIP_32;
      if (fits(first_source_operand, is_signed(ISSUE_OP), TOP_8)) begin
         skip = DIV_SKIP_8;
      end else if (fits(first_source_operand, is_signed(ISSUE_OP),
                        TOP_16)) begin
         skip = DIV_SKIP_16;
      end else if (fits(first_source_operand, is_signed(ISSUE_OP),
                        TOP_24)) begin
         skip = DIV_SKIP_24;
      end
      if (div_state_q == div_run) begin
         cyc_d = cyc_q + 6'h01;
         if (cyc_q < iter_q) begin
            rem_d = trial[33] ? shifted[31:0] : trial[31:0];
            dvd_d = {dvd_q[30:0], !trial[33]};
         end
         if (div_done) begin
            div_state_d = div_idle;
         end
      end
      if (issue_take && !is_mul(ISSUE_OP)) begin
         div_state_d = div_run;
         cyc_d  = '0;
         iter_d = DIV_FULL - skip;
         dvd_d  = mag_a << skip;
         dsr_d  = mag_b;
         rem_d  = '0;
         qneg_d = sa ^ sb;
         rneg_d = sa;
         unique case (skip)
            DIV_SKIP_8:  begin lat_d = DIV_LAT_8;  rep_d = DIV_REP_8;  end
            DIV_SKIP_16: begin lat_d = DIV_LAT_16; rep_d = DIV_REP_16; end
            DIV_SKIP_24: begin lat_d = DIV_LAT_24; rep_d = DIV_REP_24; end
            default:     begin lat_d = DIV_LAT_32; rep_d = DIV_REP_32; end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         div_state_q <= div_idle;
         cyc_q  <= '0;
         iter_q <= '0;
         lat_q  <= DIV_LAT_32;
         rep_q  <= DIV_REP_32;
         dvd_q  <= '0;
         dsr_q  <= '0;
         rem_q  <= '0;
         qneg_q <= 1'b0;
         rneg_q <= 1'b0;
      end else begin
         div_state_q <= div_state_d;
         cyc_q  <= cyc_d;
         iter_q <= iter_d;
         lat_q  <= lat_d;
         rep_q  <= rep_d;
         dvd_q  <= dvd_d;
         dsr_q  <= dsr_d;
         rem_q  <= rem_d;
         qneg_q <= qneg_d;
         rneg_q <= rneg_d;
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   sequence s_short_mul_taken;
      issue_take && is_mul(ISSUE_OP) && b_short;
   endsequence
   sequence s_long_mul_taken;
      issue_take && is_mul(ISSUE_OP) && !b_short;
   endsequence

   a_long_mul_interlock: assert property (
      ISSUE_VALID && is_mul(ISSUE_OP) && long_pending |-> ISSUE_STALL)
      else $error("second long multiply not held back");
   a_short_mul_repeat: assert property (
      s_short_mul_taken ##1 (ISSUE_VALID && is_mul(ISSUE_OP) && !DIV_BUSY)
      |-> !ISSUE_STALL)
      else $error("short multiply could not follow next clock");
   a_pass_one: assert property (
      s_short_mul_taken |=> mst_final)
      else $error("short multiply took more than one pass");
   a_pass_two: assert property (
      s_long_mul_taken |=> !mst_final ##1 mst_final)
      else $error("long multiply did not take two passes");
   a_mul_reg_latency: assert property (
      s_short_mul_taken and (ISSUE_OP == op_multiply_to_register)
      |-> ##3 MUL_RESULT_VALID) // valid flop lands at k+2, sampled at k+3
      else $error("three-operand result not on time");
   a_div8_latency: assert property (
      issue_take && !is_mul(ISSUE_OP) && skip == DIV_SKIP_8
      |-> ##12 div_done)
      else $error("short divide finished at wrong clock");
   a_div32_latency: assert property (
      issue_take && !is_mul(ISSUE_OP) && skip == DIV_SKIP_32
      |-> ##33 div_done)
      else $error("full divide finished at wrong clock");
   a_div_issue_hold: assert property (
      ISSUE_VALID && div_gate |-> ISSUE_STALL)
      else $error("issue accepted while divide still active");
   a_div_bit_step: assert property (
      DIV_BUSY && cyc_q < iter_q |=> dvd_q[31:1] == $past(dvd_q[30:0]))
      else $error("divider did not shift one bit");
   a_div_result: assert property (
      div_done && !hilo_write
      |=> RESULT_LOW == $past(div_q_res) && RESULT_HIGH == $past(div_r_res))
      else $error("divide result not in high/low");
   a_stage_advances: assert property (
      mst_valid_q && !mst_final |=> mst_final)
      else $error("multiply stage did not advance");
   a_rf_bypass: assert property (
      RF_WR_EN && RF_WR_ADDR == ISSUE_SRC_A
      |-> first_source_operand == RF_WR_DATA)
      else $error("register write not bypassed to operand");

endmodule

// ### testbench/integer_pipeline_model.sv
// integer pipeline stand-in: loads operand registers and issues operations
// assumes its tasks are called in the time step of a rising clock edge
`timescale 1ns/1ps
module integer_pipeline_model
   import op_signed_multiply_div_unit_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         stall,
   output logic              rf_wr_en,
   output logic [ADDR_W-1:0] rf_wr_addr,
   output logic [31:0]       rf_wr_data,
   output logic              issue_valid,
   output op_t               issue_op,
   output logic [ADDR_W-1:0] issue_src_a,
   output logic [ADDR_W-1:0] issue_src_b,
   output logic [ADDR_W-1:0] issue_dest
);
   initial begin
      rf_wr_en = 1'b0;
      rf_wr_addr = '0;
      rf_wr_data = '0;
      issue_valid = 1'b0;
      issue_op = op_signed_multiply;
      issue_src_a = '0;
      issue_src_b = '0;
      issue_dest = '0;
   end

   task automatic set_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      rf_wr_en <= 1'b1;
      rf_wr_addr <= a;
      rf_wr_data <= d;
   endtask

   // stall is read at the falling edge, where it has settled
   task automatic issue(input op_t op, input logic [ADDR_W-1:0] sa, sb, dst,
                        output realtime t, output bit ok);
      logic s;
      ok = 1'b0;
      issue_valid <= 1'b1;
      issue_op <= op;
      issue_src_a <= sa;
      issue_src_b <= sb;
      issue_dest <= dst;
      for (int i = 0; i < 64 && !ok; i++) begin
         @(negedge clk);
         s = stall;
         @(posedge clk);
         ok = (s === 1'b0);
      end
      t = $time;
   endtask

   // released write data is inverted so no stale value looks valid
   task automatic idle;
      issue_valid <= 1'b0;
      rf_wr_en <= 1'b0;
      rf_wr_data <= ~rf_wr_data;
   endtask
endmodule

// ### testbench/multiply_divide_unit_bench.sv
// self-checking bench for the multiply/divide unit
// assumes the pipeline model drives all issue and register file inputs
`timescale 1ns/1ps
module multiply_divide_unit_bench
   import op_signed_multiply_div_unit_pkg::*;
;
   logic        core_clk;
   logic        rst;
   logic        wr_en;
   logic [4:0]  wr_addr;
   logic [31:0] wr_data;
   logic        valid;
   op_t         op;
   logic [4:0]  src_a;
   logic [4:0]  src_b;
   logic [4:0]  dest;
   logic        stall;
   logic [31:0] res_hi;
   logic [31:0] res_lo;
   logic [31:0] mul_res;
   logic [4:0]  mul_dest;
   logic        mul_valid;
   logic        busy;
   logic [63:0] acc;
   int          fails;
   int          num_checks;

   op_signed_multiply_div_unit dut (.CORE_CLK(core_clk), .RST(rst), .RF_WR_EN(wr_en),
      .RF_WR_ADDR(wr_addr), .RF_WR_DATA(wr_data), .ISSUE_VALID(valid),
      .ISSUE_OP(op), .ISSUE_SRC_A(src_a), .ISSUE_SRC_B(src_b),
      .ISSUE_DEST(dest), .ISSUE_STALL(stall), .RESULT_HIGH(res_hi),
      .RESULT_LOW(res_lo), .MUL_RESULT(mul_res), .MUL_RESULT_DEST(mul_dest),
      .MUL_RESULT_VALID(mul_valid), .DIV_BUSY(busy));

   integer_pipeline_model pipe (.clk(core_clk), .stall(stall),
      .rf_wr_en(wr_en), .rf_wr_addr(wr_addr), .rf_wr_data(wr_data),
      .issue_valid(valid), .issue_op(op), .issue_src_a(src_a),
      .issue_src_b(src_b), .issue_dest(dest));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   function automatic logic [63:0] calc(op_t o, logic [31:0] a, b,
                                        logic [63:0] base);
      logic [63:0] ps;
      logic [63:0] pu;
      int qa;
      int qb;
      ps = {{32{a[31]}}, a} * {{32{b[31]}}, b};
      pu = {32'h0, a} * {32'h0, b};
      qa = a;
      qb = b;
      case (o)
         op_signed_multiply: return ps;
         op_unsigned_multiply: return pu;
         op_signed_multiply_accumulate: return base + ps;
         op_unsigned_multiply_accumulate: return base + pu;
         op_signed_multiply_subtract: return base - ps;
         op_unsigned_multiply_subtract: return base - pu;
         op_signed_divide: return {32'(qa % qb), 32'(qa / qb)};
         op_unsigned_divide: return {a % b, a / b};
         default: return base;
      endcase
   endfunction

   function automatic bit is_short(op_t o, logic [31:0] b);
      if (o inside {op_unsigned_multiply, op_unsigned_multiply_accumulate,
                    op_unsigned_multiply_subtract})
         return b[31:16] == 16'h0;
      return b[31:15] == 17'h0 || b[31:15] == 17'h1ffff;
   endfunction

   task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", name, exp, got);
         fails++;
      end
   endtask

   task automatic conclude;
      if (fails == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // b reaches register 2 through the same-cycle write bypass
   task automatic start(op_t o, logic [31:0] a, b, output realtime t);
      bit ok;
      pipe.set_reg(5'h01, a);
      @(posedge core_clk);
      pipe.set_reg(5'h02, b);
      pipe.issue(o, 5'h01, 5'h02, 5'h09, t, ok);
      chk("issue taken", 64'h1, {63'h0, ok});
      if (!ok)
         conclude();
   endtask

   // old value holds up to edge k+lat, new value lands exactly there
   task automatic expect_at(int lat, logic [63:0] old, nxt, logic bsy);
      repeat (lat - 1) @(posedge core_clk);
      @(negedge core_clk);
      chk("result early", old, {res_hi, res_lo});
      chk("divide busy", {63'h0, bsy}, {63'h0, busy});
      @(negedge core_clk);
      chk("result", nxt, {res_hi, res_lo});
      chk("divide idle", 64'h0, {63'h0, busy});
      @(posedge core_clk);
   endtask

   task automatic scen_reset;
      @(negedge core_clk);
      chk("reset result", 64'h0, {res_hi, res_lo});
      chk("reset flags", 64'h0, {61'h0, mul_valid, busy, stall});
      @(posedge core_clk);
   endtask

   task automatic scen_mul_table;
      logic [31:0] bs [3] = '{32'hffff_fffd, 32'h0000_8000, 32'h0001_2345};
      logic [63:0] nxt;
      realtime t;
      int lat;
      for (int o = 0; o < 6; o++)
         for (int i = 0; i < 3; i++) begin
            nxt = calc(op_t'(o), 32'h8000_0003, bs[i], acc);
            start(op_t'(o), 32'h8000_0003, bs[i], t);
            pipe.idle();
            lat = is_short(op_t'(o), bs[i]) ? 1 : 2;
            expect_at(lat, acc, nxt, 1'b0);
            acc = nxt;
         end
   endtask

   // an accumulate right behind a multiply builds on its product
   task automatic scen_back_to_back(logic [31:0] b, int lat);
      realtime t1;
      realtime t2;
      bit ok;
      logic [63:0] p;
      p = calc(op_signed_multiply, 32'h0000_0b0d, b, 64'h0);
      start(op_signed_multiply, 32'h0000_0b0d, b, t1);
      pipe.issue(op_signed_multiply_accumulate, 5'h01, 5'h02, 5'h09, t2, ok);
      pipe.idle();
      chk("follow taken", 64'h1, {63'h0, ok});
      if (!ok)
         conclude();
      chk("issue gap", 64'(lat), 64'(int'((t2 - t1) / 8.0)));
      expect_at(lat, p, p + p, 1'b0);
      acc = p + p;
   endtask

   task automatic scen_mul_reg(logic [31:0] b, int lat);
      realtime t;
      logic [63:0] p;
      logic [63:0] w;
      p = calc(op_signed_multiply, 32'hc001_0005, b, 64'h0);
      w = {27'h0, 5'h09, p[31:0]};
      start(op_multiply_to_register, 32'hc001_0005, b, t);
      pipe.idle();
      repeat (lat - 1) @(posedge core_clk);
      for (int i = 0; i < 3; i++) begin
         @(negedge core_clk);
         chk("mul valid", {63'h0, i == 1}, {63'h0, mul_valid});
         if (i == 1)
            chk("mul result", w, {27'h0, mul_dest, mul_res});
      end
      chk("high low kept", acc, {res_hi, res_lo});
      @(posedge core_clk);
   endtask

   task automatic scen_divide(op_t o, logic [31:0] a, b, int lat, rep);
      realtime t1;
      realtime t2;
      bit ok;
      logic [63:0] q;
      q = calc(o, a, b, acc);
      start(o, a, b, t1);
      pipe.idle();
      expect_at(lat, acc, q, 1'b1);
      acc = q;
      start(o, a, b, t1);
      pipe.issue(op_signed_multiply_accumulate, 5'h01, 5'h02, 5'h09, t2, ok);
      pipe.idle();
      chk("after divide taken", 64'h1, {63'h0, ok});
      if (!ok)
         conclude();
      chk("divide repeat", 64'(rep), 64'(int'((t2 - t1) / 8.0)));
      q = calc(op_signed_multiply_accumulate, a, b, q);
      expect_at(1, acc, q, 1'b1);
      acc = q;
   endtask

   initial begin
      fails = 0;
      num_checks = 0;
      acc = 64'h0;
      rst = 1'b1;
      repeat (11) @(posedge core_clk);
      scen_reset();
      rst <= 1'b0;
      scen_mul_table();
      scen_back_to_back(32'h0000_7fff, 1);
      scen_back_to_back(32'h0001_2345, 2);
      scen_mul_reg(32'h0000_7fff, 2);
      scen_mul_reg(32'h0001_2345, 3);
      scen_divide(op_signed_divide, 32'hffff_ff9c, 32'h0000_0007,
                  12, 11);
      scen_divide(op_unsigned_divide, 32'h0000_7abc, 32'h0000_0013,
                  19, 18);
      scen_divide(op_signed_divide, 32'hff80_1234, 32'hffff_fff9,
                  26, 25);
      scen_divide(op_unsigned_divide, 32'h8765_4321, 32'h0000_1234,
                  33, 32);
      conclude();
   end
endmodule
